//--- ew_core.sv
// Serial interface and mode sequencer of the hundred-word nonvolatile word store.
// Contract
// R01 - Three select lines carry a code for seven modes; one code is unused.
// R02 - Store 100 words of 14 bits, altered one word at a time.
// R03 - Standby keeps address and data registers unchanged and the pin floating.
// R04 - Erase clears every bit of the addressed word to low.
// R05 - Accept address shifts the pin into the address register; two one-of-ten digits.
// R06 - Read copies the addressed word into the data register.
// R07 - Shift data output drives the pin and shifts the data register out.
// R08 - Write programs the data register into the addressed word.
// R09 - Accept data shifts the pin into the data register, address untouched.
// R10 - Pin is input for address and data, output for shift, floating otherwise.
// R11 - Controller supplies about 14 kHz clock; may hold it high in standby.
// R12 - Controller changes mode lines and input data only while clock is high.
// R13 - First output bit follows the mode change, later bits a rising edge.
// R14 - Controller holds erase or write 16 to 24 ms; update is erase then write.
`timescale 1ns/1ps
`include "ew_map.svh"
module ew_core #(
    parameter int unsigned PROG_CYCLES = `EW_PROG_CYCLES
) (
    // System clock and reset.
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    // Controller pins.
    input  wire logic                     dev_clk_i,
    input  wire logic [`EW_MODE_BITS-1:0] mode_sel_i,
    input  wire logic                     dio_i,
    // Bidirectional data pin, drive side.
    output logic                          dio_o,
    output logic                          dio_oe_o
);
    localparam ew_pkg::ew_core_t CORE_RST = '{
        mode:    ew_pkg::ew_standby,
        phi:     1'b1,
        default: '0
    };

    ew_pkg::ew_core_t            st_r;
    ew_pkg::ew_core_t            st_nxt;
    logic [`EW_SYNC_BITS-1:0]    sync_q;
    logic                        phi;
    logic                        din;
    ew_pkg::ew_mode_t            cur_mode;
    logic                        entered;
    logic                        phi_rise;
    logic                        phi_fall;
    logic [`EW_IDX_BITS:0]       dec;
    logic                        addr_ok;

    ew_mem_if #(.IDX_W(`EW_IDX_BITS), .DW(`EW_WORD_BITS)) mi ();

    // R11 clock pin sampled
    // The controller clock is only a slow pin here, so it shares the synchroniser
    // with the mode lines and data; all three then see the same latency.
    ew_sync #(
        .W       (`EW_SYNC_BITS),
        .RST_VAL (`EW_SYNC_RST)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({dev_clk_i, mode_sel_i, dio_i}),
        .sync_o    (sync_q)
    );

    // R02 word array
    ew_mem #(
        .WORDS (`EW_WORDS),
        .DW    (`EW_WORD_BITS)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .mi        (mi)
    );

    // R01 mode decode
    // Every code maps to an enum member, so the cast cannot produce a stray value.
    assign cur_mode = ew_pkg::ew_mode_t'(sync_q[`EW_SYNC_MODE_HI:`EW_SYNC_MODE_LO]);
    assign phi      = sync_q[`EW_SYNC_PHI];
    assign din      = sync_q[`EW_SYNC_DIN];
    assign entered  = (cur_mode != st_r.mode);
    assign phi_rise = phi && !st_r.phi;
    assign phi_fall = !phi && st_r.phi;

    // R05 one-of-ten address decode
    // A pattern that is not exactly one bit per digit selects no word at all.
    assign dec     = ew_pkg::ew_addr_decode(st_r.addr);
    assign addr_ok = dec[`EW_IDX_BITS];

    // Next-state logic of the sequencer, one branch per mode; erase and write share one.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.phi      = phi;
        st_nxt.mode     = cur_mode;
        st_nxt.rd_pend  = 1'b0;
        mi.we           = 1'b0;
        mi.re           = 1'b0;
        mi.idx          = dec[`EW_IDX_BITS-1:0];
        mi.wdata        = st_r.data;
        // R10 pin direction
        st_nxt.dio_oe   = (cur_mode == ew_pkg::ew_shift_out);
        // R06 load read word
        // Array data arrive one cycle after the request; an invalid address reads zero.
        if (st_r.rd_pend) begin
            st_nxt.data = st_r.rd_valid ? mi.rdata : '0;
        end
        case (cur_mode)
            ew_pkg::ew_accept_addr: begin
                // R12 sample on clock fall
                // The controller only moves data while the clock is high, so the
                // falling edge is the point where the level is known to be settled.
                if (phi_fall) begin
                    // R05 address shift in
                    st_nxt.addr = {st_r.addr[`EW_ADDR_BITS-2:0], din};
                end
            end
            ew_pkg::ew_accept_data: begin
                if (phi_fall) begin
                    // R09 data shift in
                    st_nxt.data = {st_r.data[`EW_WORD_BITS-2:0], din};
                end
            end
            ew_pkg::ew_shift_out: begin
                if (entered) begin
                    // R13 first bit on entry
                    st_nxt.dio = st_r.data[`EW_WORD_BITS-1];
                end else if (phi_rise) begin
                    // R07 rotate word out
                    // Rotating keeps the word intact for a second read-out pass.
                    st_nxt.data = {st_r.data[`EW_WORD_BITS-2:0], st_r.data[`EW_WORD_BITS-1]};
                    st_nxt.dio  = st_r.data[`EW_WORD_BITS-2];
                end
            end
            ew_pkg::ew_read: begin
                if (entered) begin
                    // R06 read request
                    mi.re           = addr_ok;
                    st_nxt.rd_pend  = 1'b1;
                    st_nxt.rd_valid = addr_ok;
                end
            end
            ew_pkg::ew_erase,
            ew_pkg::ew_write: begin
                // R14 program hold time
                // The cell is altered only once the code has been held for the least
                // program time; leaving earlier aborts and leaves the word as it was.
                if (entered) begin
                    st_nxt.cnt  = '0;
                    st_nxt.done = 1'b0;
                end else if (!st_r.done) begin
                    if (st_r.cnt == `EW_CNT_BITS'(PROG_CYCLES - 1)) begin
                        st_nxt.done = 1'b1;
                        // R08 commit to array
                        mi.we       = addr_ok;
                        // R04 erase to zero
                        if (cur_mode == ew_pkg::ew_erase) begin
                            mi.wdata = '0;
                        end
                    end else begin
                        st_nxt.cnt = st_r.cnt + `EW_CNT_BITS'(1);
                    end
                end
            end
            // R03 standby holds state
            ew_pkg::ew_standby: begin
                st_nxt.cnt = st_r.cnt;
            end
            default: begin
                st_nxt.cnt = st_r.cnt;
            end
        endcase
    end

    // State register; reset starts in standby with the pin released.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r <= CORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pin drive comes straight from the state register.
    assign dio_o    = st_r.dio;
    assign dio_oe_o = st_r.dio_oe;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_std_hold;
        (cur_mode == ew_pkg::ew_standby && !st_r.rd_pend)
            |=> ($stable(st_r.addr) && $stable(st_r.data) && !dio_oe_o);
    endproperty
    a_std_hold: assert property (p_std_hold) // R03
        else $error("standby altered state or drove pin");

    property p_addr_shift;
        (cur_mode == ew_pkg::ew_accept_addr && phi_fall)
            |=> (st_r.addr == {$past(st_r.addr[`EW_ADDR_BITS-2:0]), $past(din)});
    endproperty
    a_addr_shift: assert property (p_addr_shift) else $error("address bit not shifted in"); // R05

    property p_data_shift;
        (cur_mode == ew_pkg::ew_accept_data && phi_fall && !st_r.rd_pend)
            |=> (st_r.data == {$past(st_r.data[`EW_WORD_BITS-2:0]), $past(din)})
                && $stable(st_r.addr);
    endproperty
    a_data_shift: assert property (p_data_shift) else $error("data bit not shifted in"); // R09

    property p_out_first;
        (cur_mode == ew_pkg::ew_shift_out && entered)
            |=> (dio_oe_o && dio_o == $past(st_r.data[`EW_WORD_BITS-1]));
    endproperty
    a_out_first: assert property (p_out_first) else $error("first output bit wrong"); // R13

    property p_out_next;
        (cur_mode == ew_pkg::ew_shift_out && !entered && phi_rise && !st_r.rd_pend)
            |=> (dio_o == $past(st_r.data[`EW_WORD_BITS-2]));
    endproperty
    a_out_next: assert property (p_out_next) else $error("next output bit wrong"); // R07

    property p_oe_float;
        (cur_mode != ew_pkg::ew_shift_out) |=> !dio_oe_o;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("pin driven outside shift mode"); // R10

    property p_read_load;
        (cur_mode == ew_pkg::ew_read && entered && addr_ok) |-> ##2 (st_r.data == mi.rdata);
    endproperty
    a_read_load: assert property (p_read_load) else $error("read word not loaded"); // R06

    property p_erase_zero;
        (mi.we && cur_mode == ew_pkg::ew_erase) |-> (mi.wdata == '0);
    endproperty
    a_erase_zero: assert property (p_erase_zero) else $error("erase wrote nonzero bits"); // R04

    property p_write_time;
        mi.we |-> (st_r.cnt == `EW_CNT_BITS'(PROG_CYCLES - 1) && !st_r.done && addr_ok
                   && (cur_mode == ew_pkg::ew_erase || mi.wdata == st_r.data));
    endproperty
    a_write_time: assert property (p_write_time) // R08
        else $error("array written early or wrong word");

    // Further checks, each on state or strobes that the sequencer itself drives.
    property p_unused_hold;
        (cur_mode == ew_pkg::ew_unused && !st_r.rd_pend)
            |=> ($stable(st_r.addr) && $stable(st_r.data) && !dio_oe_o);
    endproperty
    a_unused_hold: assert property (p_unused_hold) // R01
        else $error("unused code altered state or drove pin");

    property p_read_once;
        mi.re |-> (cur_mode == ew_pkg::ew_read && entered && addr_ok);
    endproperty
    a_read_once: assert property (p_read_once) // R06
        else $error("array read outside read entry");

    property p_read_bad;
        (cur_mode == ew_pkg::ew_read && entered && !addr_ok) |-> ##2 (st_r.data == '0);
    endproperty
    a_read_bad: assert property (p_read_bad) // R06
        else $error("refused address did not read zero");

    property p_oe_on;
        (cur_mode == ew_pkg::ew_shift_out) |=> dio_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) // R10
        else $error("pin not driven in shift mode");

    property p_dio_hold;
        (cur_mode == ew_pkg::ew_shift_out && !entered && !phi_rise) |=> $stable(dio_o);
    endproperty
    a_dio_hold: assert property (p_dio_hold) // R07
        else $error("output bit moved without a clock rise");

    property p_rotate;
        (cur_mode == ew_pkg::ew_shift_out && !entered && phi_rise && !st_r.rd_pend)
            |=> (st_r.data == {$past(st_r.data[`EW_WORD_BITS-2:0]),
                               $past(st_r.data[`EW_WORD_BITS-1])});
    endproperty
    a_rotate: assert property (p_rotate) // R07
        else $error("data register not rotated on output");

    property p_addr_hold;
        (cur_mode != ew_pkg::ew_accept_addr) |=> $stable(st_r.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) // R09
        else $error("address changed outside accept address");

    property p_entry_clear;
        (entered && (cur_mode == ew_pkg::ew_erase || cur_mode == ew_pkg::ew_write))
            |=> (st_r.cnt == '0 && !st_r.done);
    endproperty
    a_entry_clear: assert property (p_entry_clear) // R14
        else $error("program timer not restarted on entry");

    property p_we_mode;
        mi.we |-> (cur_mode == ew_pkg::ew_erase || cur_mode == ew_pkg::ew_write);
    endproperty
    a_we_mode: assert property (p_we_mode) // R08
        else $error("array written outside erase or write");

    property p_commit;
        (cur_mode == ew_pkg::ew_write && !entered && !st_r.done && addr_ok
         && st_r.cnt == `EW_CNT_BITS'(PROG_CYCLES - 1))
            |-> (mi.we && mi.wdata == st_r.data);
    endproperty
    a_commit: assert property (p_commit) // R08
        else $error("write not committed at end of hold");
endmodule

//--- ew_core_bench.sv
// Self-checking bench for the serial word store sequencer.
`timescale 1ns/1ps
`include "ew_map.svh"
module ew_core_bench;
    localparam int PROG = 50;

    logic                     clk_sys_i;
    logic                     sys_rst_i;
    logic                     dev_clk_i;
    logic [`EW_MODE_BITS-1:0] mode_sel_i;
    logic                     dio_i;
    logic                     dio_o;
    logic                     dio_oe_o;
    int                       n_fail;
    int                       checks_done;

    // Short program time keeps erase and write holds to a few clocks.
    ew_core #(.PROG_CYCLES(PROG)) ew_core_i (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .dev_clk_i  (dev_clk_i),
        .mode_sel_i (mode_sel_i),
        .dio_i      (dio_i),
        .dio_o      (dio_o),
        .dio_oe_o   (dio_oe_o)
    );

    ew_ctl_model ew_ctl_model_i (
        .clk_sys_i  (clk_sys_i),
        .dio_o      (dio_o),
        .dio_oe_o   (dio_oe_o),
        .dev_clk_o  (dev_clk_i),
        .mode_sel_o (mode_sel_i),
        .dio_wire_o (dio_i)
    );

    // 100 MHz system clock.
    always #5 clk_sys_i = ~clk_sys_i;

    task automatic wrap_up();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [`EW_WORD_BITS-1:0] got,
                            input logic [`EW_WORD_BITS-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Two one-of-ten digits, tens digit in the first ten bits sent.
    function automatic logic [19:0] addr_of(input int idx);
        return (20'h00001 << (10 + idx / 10)) | (20'h00001 << (idx % 10));
    endfunction

    task automatic store(input int idx, input logic [`EW_WORD_BITS-1:0] w);
        logic oe;
        ew_ctl_model_i.shift_in(`EW_MODE_ADDR, addr_of(idx), 20);
        ew_ctl_model_i.shift_in(`EW_MODE_DATA, {6'h00, w}, 14);
        ew_ctl_model_i.hold(`EW_MODE_ERASE, 4, oe);
        chk_bit(oe, 1'b0);
        ew_ctl_model_i.hold(`EW_MODE_WRITE, 4, oe);
        chk_bit(oe, 1'b0);
    endtask

    task automatic fetch(input int idx, output logic [`EW_WORD_BITS-1:0] w);
        logic oe;
        ew_ctl_model_i.shift_in(`EW_MODE_ADDR, addr_of(idx), 20);
        ew_ctl_model_i.hold(`EW_MODE_READ, 1, oe);
        chk_bit(oe, 1'b0);
        ew_ctl_model_i.shift_out(w, oe);
        chk_bit(oe, 1'b1);
    endtask

    // Corner words and a middle one, each with its own pattern.
    task automatic t_roundtrip();
        logic [`EW_WORD_BITS-1:0] w;
        store(0, 14'h2a5c);
        store(99, 14'h1337);
        store(23, 14'h3fff);
        fetch(0, w);
        chk_word(w, 14'h2a5c);
        fetch(99, w);
        chk_word(w, 14'h1337);
        fetch(23, w);
        chk_word(w, 14'h3fff);
    endtask

    // Erase alone must leave the word all low.
    task automatic t_erase();
        logic [`EW_WORD_BITS-1:0] w;
        logic                     oe;
        store(41, 14'h3ffe);
        ew_ctl_model_i.hold(`EW_MODE_ERASE, 4, oe);
        fetch(41, w);
        chk_word(w, 14'h0000);
    endtask

    // An erase left too early must not touch the word.
    task automatic t_abort();
        logic [`EW_WORD_BITS-1:0] w;
        logic                     oe;
        store(45, 14'h0a0a);
        ew_ctl_model_i.hold(`EW_MODE_ERASE, 1, oe);
        fetch(45, w);
        chk_word(w, 14'h0a0a);
    endtask

    // Standby and the unused code keep both registers while the pin and clock move.
    task automatic t_standby();
        logic [`EW_WORD_BITS-1:0] w;
        logic                     oe;
        store(12, 14'h1c3a);
        store(77, 14'h2461);
        fetch(12, w);
        ew_ctl_model_i.shift_in(`EW_MODE_STANDBY, 20'h5a5a5, 20);
        chk_bit(dio_oe_o, 1'b0);
        ew_ctl_model_i.shift_in(`EW_MODE_UNUSED, 20'ha5a5a, 20);
        ew_ctl_model_i.shift_out(w, oe);
        chk_word(w, 14'h1c3a);
        ew_ctl_model_i.hold(`EW_MODE_READ, 1, oe);
        ew_ctl_model_i.shift_out(w, oe);
        chk_word(w, 14'h1c3a);
    endtask

    // Two tens digits set: the address is refused and the read gives zero.
    task automatic t_bad_addr();
        logic [`EW_WORD_BITS-1:0] w;
        logic                     oe;
        ew_ctl_model_i.shift_in(`EW_MODE_ADDR, 20'h0c008, 20);
        ew_ctl_model_i.hold(`EW_MODE_READ, 1, oe);
        ew_ctl_model_i.shift_out(w, oe);
        chk_word(w, 14'h0000);
    endtask

    // Watchdog: a run that overstays counts as a failure.
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_fail++;
        wrap_up();
    end

    initial begin
        clk_sys_i   = 1'b0;
        sys_rst_i   = 1'b1;
        n_fail      = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk_bit(dio_oe_o, 1'b0);
        t_roundtrip();
        t_erase();
        t_abort();
        t_standby();
        t_bad_addr();
        wrap_up();
    end
endmodule

//--- ew_ctl_model.sv
// Controller model that drives the clock, mode and data pins of the word store.
`timescale 1ns/1ps
`include "ew_map.svh"
module ew_ctl_model #(
    parameter int HALF = 8
) (
    // System clock.
    input  wire logic                     clk_sys_i,
    // Drive side of the store's data pin.
    input  wire logic                     dio_o,
    input  wire logic                     dio_oe_o,
    // Pins toward the store.
    output logic                          dev_clk_o,
    output logic [`EW_MODE_BITS-1:0]      mode_sel_o,
    output logic                          dio_wire_o
);
    logic drv_en;
    logic drv_val;

    // pin level resolved
    // A released pin shows the inverse of the last level the controller drove, so a
    // stale value can never pass as data.
    assign dio_wire_o = dio_oe_o ? dio_o : (drv_en ? drv_val : ~drv_val);

    // Idle pins: clock high, standby, data released.
    initial begin
        dev_clk_o  = 1'b1;
        mode_sel_o = `EW_MODE_STANDBY;
        drv_en     = 1'b0;
        drv_val    = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic set_mode(input logic [`EW_MODE_BITS-1:0] m);
        mode_sel_o <= m;
        wait_cyc(HALF);
    endtask

    task automatic pulse();
        dev_clk_o <= 1'b0;
        wait_cyc(HALF);
        dev_clk_o <= 1'b1;
        wait_cyc(HALF);
    endtask

    task automatic shift_in(input logic [`EW_MODE_BITS-1:0] m, input logic [19:0] bits,
                            input int n);
        set_mode(m);
        drv_en <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            drv_val <= bits[i];
            wait_cyc(HALF);
            pulse();
        end
        drv_en <= 1'b0;
        set_mode(`EW_MODE_STANDBY);
        pulse();
    endtask

    // hold a mode for a number of clocks
    // The pin's output enable is sampled in the mode so a driver that turns on is caught.
    task automatic hold(input logic [`EW_MODE_BITS-1:0] m, input int n, output logic oe);
        set_mode(m);
        oe = dio_oe_o;
        repeat (n) pulse();
        oe = oe | dio_oe_o;
        set_mode(`EW_MODE_STANDBY);
        pulse();
    endtask

    // first bit after entry, later bits after each rise
    task automatic shift_out(output logic [`EW_WORD_BITS-1:0] w, output logic oe);
        set_mode(`EW_MODE_SHIFT);
        w[13] = dio_o;
        oe    = dio_oe_o;
        for (int i = 12; i >= 0; i--) begin
            pulse();
            w[i] = dio_o;
            oe   = oe & dio_oe_o;
        end
        // fourteenth pulse
        // The last rise completes the rotation, so the word stands as it was read.
        pulse();
        set_mode(`EW_MODE_STANDBY);
        pulse();
    endtask
endmodule

//--- ew_map.svh
// Constants for the serial word store: sizes, mode codes, sampling slots and timing.
`ifndef EW_MAP_SVH
`define EW_MAP_SVH

// Array shape and serial register widths.
`define EW_WORDS        100
`define EW_WORD_BITS    14
`define EW_IDX_BITS     7
`define EW_DIGIT_BITS   10
`define EW_ADDR_BITS    20
`define EW_MODE_BITS    3

// Mode codes, first select line in the top bit.
`define EW_MODE_STANDBY 3'h7
`define EW_MODE_UNUSED  3'h6
`define EW_MODE_ERASE   3'h5
`define EW_MODE_ADDR    3'h4
`define EW_MODE_READ    3'h3
`define EW_MODE_SHIFT   3'h2
`define EW_MODE_WRITE   3'h1
`define EW_MODE_DATA    3'h0

// Slots of the pin synchroniser vector.
`define EW_SYNC_BITS    5
`define EW_SYNC_PHI     4
`define EW_SYNC_MODE_HI 3
`define EW_SYNC_MODE_LO 1
`define EW_SYNC_DIN     0
`define EW_SYNC_RST     5'h1e

// System clock rate and the least program time, rounded up to cycles.
`define EW_CLK_HZ       100000000
`define EW_PROG_MIN_MS  16
`define EW_PROG_CYCLES  ((`EW_PROG_MIN_MS * `EW_CLK_HZ + 999) / 1000)
`define EW_CNT_BITS     32

`endif

//--- ew_mem.sv
// Word array of the store with a registered read port.
`timescale 1ns/1ps
module ew_mem #(
    parameter int WORDS = 100,
    parameter int DW    = 14
) (
    // Clock and reset.
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // Access port.
    ew_mem_if.mem     mi
);
    logic [DW-1:0] mem_r [0:WORDS-1];
    logic [DW-1:0] rdata_r;

    // The cells are nonvolatile, so reset leaves them alone; only the read register resets.
    always_ff @(posedge clk_sys_i) begin
        if (mi.we) begin
            mem_r[mi.idx] <= mi.wdata;
        end
        if (sys_rst_i) begin
            rdata_r <= '0;
        end else if (mi.re) begin
            rdata_r <= mem_r[mi.idx];
        end
    end

    assign mi.rdata = rdata_r;

    property p_mem_rw;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (mi.we ##1 (mi.re && !mi.we && mi.idx == $past(mi.idx)))
            |=> (mi.rdata == $past(mi.wdata, 2));
    endproperty
    a_mem_rw: assert property (p_mem_rw) // R02
        else $error("word read back differs from word written");
endmodule

//--- ew_mem_if.sv
// Carrier between the sequencer and the word array.
`timescale 1ns/1ps
interface ew_mem_if #(
    parameter int IDX_W = 7,
    parameter int DW    = 14
);
    logic             we;
    logic             re;
    logic [IDX_W-1:0] idx;
    logic [DW-1:0]    wdata;
    logic [DW-1:0]    rdata;

    modport ctl (output we, output re, output idx, output wdata, input rdata);
    modport mem (input we, input re, input idx, input wdata, output rdata);
endinterface

//--- ew_pkg.sv
// Types and the address decoder shared by the serial word store.
package ew_pkg;
`include "ew_map.svh"

    // Operating modes, encoded exactly as the select-line code.
    typedef enum logic [2:0] {
        ew_accept_data = 3'b000,
        ew_write       = 3'b001,
        ew_shift_out   = 3'b010,
        ew_read        = 3'b011,
        ew_accept_addr = 3'b100,
        ew_erase       = 3'b101,
        ew_unused      = 3'b110,
        ew_standby     = 3'b111
    } ew_mode_t;

    // Whole state of the sequencer.
    typedef struct packed {
        ew_mode_t                    mode;
        logic                        phi;
        logic [`EW_ADDR_BITS-1:0]    addr;
        logic [`EW_WORD_BITS-1:0]    data;
        logic                        dio;
        logic                        dio_oe;
        logic [`EW_CNT_BITS-1:0]     cnt;
        logic                        done;
        logic                        rd_pend;
        logic                        rd_valid;
    } ew_core_t;

    // Two one-of-ten digits to {valid, word index}; tens digit sits in the upper half.
    function automatic logic [`EW_IDX_BITS:0] ew_addr_decode(
        input logic [`EW_ADDR_BITS-1:0] a
    );
        logic [3:0] tens;
        logic [3:0] ones;
        int         n_t;
        int         n_o;
        tens = 4'h0;
        ones = 4'h0;
        n_t  = 0;
        n_o  = 0;
        for (int i = 0; i < `EW_DIGIT_BITS; i++) begin
            if (a[`EW_DIGIT_BITS+i]) begin
                tens = 4'(i);
                n_t++;
            end
            if (a[i]) begin
                ones = 4'(i);
                n_o++;
            end
        end
        return {(n_t == 1) && (n_o == 1), 7'(tens * 10 + ones)};
    endfunction
endpackage

//--- ew_sync.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module ew_sync #(
    parameter int           W       = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // Pins in, clean levels out.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ew_sync_st_t;

    ew_sync_st_t st_r;
    ew_sync_st_t st_nxt;

    // Per bit, the output follows only when stages two and three hold the same level.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q  = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    // Reset loads idle levels so no false edge appears on release.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.q;

    property p_sync_agree;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r.q != $past(st_r.q)) |-> ($past(st_r.s2) == $past(st_r.s3));
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("sync output moved without agreement");
endmodule
